// ### rtl/sicc_map.svh
// Register offsets, field positions and reset values of the interface configuration block.
`ifndef SICC_MAP_SVH
`define SICC_MAP_SVH
`define SICC_ADDR_W           6
`define SICC_CFG_ADDR         6'h02
`define SICC_CHK_ADDR         6'h03
`define SICC_CFG_RESET        16'h0000
`define SICC_CFG_RW_MASK      16'h19e0
`define SICC_BIT_ALTERNATE_SYNC_ENABLE     12
`define SICC_BIT_DRIVE_BOOST  11
`define SICC_BIT_OUT_RESET    8
`define SICC_BIT_CONT_READ    7
`define SICC_BIT_DATA_STATUS  6
`define SICC_BIT_CHECK_EN     5
`define SICC_MODE_CONTINUOUS  3'h0
`define SICC_CHK_W            24
`endif

// ### rtl/sicc_pkg.sv
// Types shared by the interface configuration block.
package sicc_pkg;
  typedef logic [15:0] sicc_cfg_t;
  typedef logic [23:0] sicc_chk_t;
  typedef enum logic [1:0] {SICC_CHK_OFF, SICC_CHK_ARM, SICC_CHK_WATCH} sicc_chk_state_e;
endpackage

// ### rtl/sicc_xor_fold.sv
// Combinational XOR fold of the checked user registers into a 24-bit checksum.
`timescale 1ns/1ps
`include "sicc_map.svh"
module sicc_xor_fold #(
  parameter int NUM_REGS = 8
) (
  input  wire logic [NUM_REGS*24-1:0] regs_i,
  output logic      [23:0]            sum_o
);
  // Fold every 24-bit slot into one word.
  always_comb
  begin
    sum_o = 24'h000000;
    for (int k = 0; k < NUM_REGS; k++)
    begin
      sum_o = sum_o ^ regs_i[k*24 +: 24];
    end
  end
endmodule

// ### rtl/sicc_top.sv
// Serial interface configuration register with the user-register integrity checker.
`timescale 1ns/1ps
`include "sicc_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: Configuration register at 0x02, 16 bits, resets to zero.
// R2: Bits 15:13, 10:9, 4 reserved, read-only; host writes zero.
// R3: Bit 12 selects alternate conversion-sync pin behaviour.
// R4: Bit 11 boosts drive strength of the data-out/ready pin.
// R5: Bit 8 enables output-pin reset behaviour, reset zero.
// R6: Bit 7 enables continuous read of the data register.
// R7: Host sets continuous conversion mode before continuous read.
// R8: Bit 6 appends status contents after each data read.
// R9: Bit 5 enables monitoring; any change sets integrity error flag.
// R10: Writing zero to the check enable bit clears the error flag.
// R11: Configuration, data and status registers are not checked.
// R12: Host configures registers with check off, then enables it.
// R13: Writes of new contents while checking raise the error.
// R14: Checksum at 0x03 is XOR of user registers, else zero.
// R15: Mode field value 000 means continuous conversion.
// R16: Reference checksum captured on enable, compared every cycle.
// R17: Writes update on completion; reserved bits read zero.
module sicc_top
  import sicc_pkg::*;
#(
  parameter int NUM_REGS = 8
) (
  input  wire logic                     REF_CLK_I,
  input  wire logic                     RST_I,
  input  wire logic                     WR_STB_I,
  input  wire logic                     RD_STB_I,
  input  wire logic [5:0]               ADDR_I,
  input  wire logic [15:0]              WDATA_I,
  input  wire logic [NUM_REGS*24-1:0]   USER_REGS_I,
  input  wire logic [2:0]               ADC_MODE_I,
  output sicc_pkg::sicc_chk_t           RDATA_O,
  output logic                          ALTERNATE_SYNC_ENABLE_ENABLE_O,
  output logic                          OUTPUT_DRIVE_BOOST_O,
  output logic                          OUT_RESET_ENABLE_O,
  output logic                          CONTINUOUS_READ_ENABLE_O,
  output logic                          CONT_READ_ACTIVE_O,
  output logic                          DATA_STATUS_APPEND_O,
  output logic                          INTEGRITY_ERROR_O
);
  import sicc_pkg::*;

  sicc_cfg_t       cfg_q;
  sicc_chk_t       live_sum;
  sicc_chk_t       ref_q;
  sicc_chk_state_e chk_q;
  logic            err_q;
  logic            cfg_wr;
  logic            chk_en;

  // Register select shared by the write decode, the read mux and the checks.
  function automatic logic addr_hit(input logic [5:0] addr, input logic [5:0] target);
    return addr == target;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode of the configuration register.
  assign cfg_wr = WR_STB_I && addr_hit(ADDR_I, `SICC_CFG_ADDR);
  assign chk_en = cfg_q[`SICC_BIT_CHECK_EN];

  // Read-write bits load on the completing write; reserved bits stay zero.
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      cfg_q <= `SICC_CFG_RESET; // [R1]
    else if (cfg_wr)
      cfg_q <= WDATA_I & `SICC_CFG_RW_MASK; // [R2] [R17]
  end

  // Configuration bits registered once on the way to the pins they steer.
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      ALTERNATE_SYNC_ENABLE_ENABLE_O        <= 1'b0;
      OUTPUT_DRIVE_BOOST_O     <= 1'b0;
      OUT_RESET_ENABLE_O       <= 1'b0;
      CONTINUOUS_READ_ENABLE_O <= 1'b0;
      CONT_READ_ACTIVE_O       <= 1'b0;
      DATA_STATUS_APPEND_O     <= 1'b0;
    end
    else
    begin
      ALTERNATE_SYNC_ENABLE_ENABLE_O        <= cfg_q[`SICC_BIT_ALTERNATE_SYNC_ENABLE]; // [R3]
      OUTPUT_DRIVE_BOOST_O     <= cfg_q[`SICC_BIT_DRIVE_BOOST]; // [R4]
      OUT_RESET_ENABLE_O       <= cfg_q[`SICC_BIT_OUT_RESET]; // [R5]
      CONTINUOUS_READ_ENABLE_O <= cfg_q[`SICC_BIT_CONT_READ]; // [R6]
      // Continuous read only runs while converting continuously.
      CONT_READ_ACTIVE_O       <= cfg_q[`SICC_BIT_CONT_READ]
                                  && (ADC_MODE_I == `SICC_MODE_CONTINUOUS); // [R7] [R15]
      DATA_STATUS_APPEND_O     <= cfg_q[`SICC_BIT_DATA_STATUS]; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksum over the user registers only; config, data and status are not wired in.
  sicc_xor_fold #(
    .NUM_REGS (NUM_REGS)
  ) u_fold (
    .regs_i (USER_REGS_I), // [R11]
    .sum_o  (live_sum)
  );

  // Checker sequencing: arm is entered one cycle after enable rises and captures the reference one cycle later.
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      chk_q <= SICC_CHK_OFF;
      ref_q <= 24'h000000;
    end
    else
    begin
      case (chk_q)
        SICC_CHK_OFF:
        begin
          if (chk_en)
            chk_q <= SICC_CHK_ARM;
        end
        SICC_CHK_ARM:
        begin
          ref_q <= live_sum; // [R16]
          chk_q <= chk_en ? SICC_CHK_WATCH : SICC_CHK_OFF;
        end
        default:
        begin
          if (!chk_en)
            chk_q <= SICC_CHK_OFF;
        end
      endcase
    end
  end

  // Error flag: any change while watching sets it; only reset or clearing the enable clears it.
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      err_q <= 1'b0;
    else if (chk_q == SICC_CHK_WATCH && chk_en && live_sum != ref_q)
      err_q <= 1'b1; // [R9] [R13]
    else if (!chk_en)
      err_q <= 1'b0; // [R10]
  end

  // The flag reaches its pin one register later, so the pin comes from a flip-flop.
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      INTEGRITY_ERROR_O <= 1'b0;
    else
      INTEGRITY_ERROR_O <= err_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read port; checksum reads zero while disabled, unmapped reads zero.
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      RDATA_O <= 24'h000000;
    else if (RD_STB_I)
    begin
      if (addr_hit(ADDR_I, `SICC_CFG_ADDR))
        RDATA_O <= {8'h00, cfg_q}; // [R17]
      else if (addr_hit(ADDR_I, `SICC_CHK_ADDR))
        RDATA_O <= chk_en ? live_sum : 24'h000000; // [R14]
      else
        RDATA_O <= 24'h000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reserved bits never hold a one, a completed write lands whole and reads back.
  a_reserved_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R2]
    (cfg_q & ~`SICC_CFG_RW_MASK) == 16'h0000)
    else $error("reserved bit set");
  a_write_loads: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R17]
    cfg_wr |=> cfg_q == ($past(WDATA_I) & `SICC_CFG_RW_MASK))
    else $error("config write lost");
  a_cfg_readback: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R17]
    (RD_STB_I && addr_hit(ADDR_I, `SICC_CFG_ADDR)) |=> RDATA_O == {8'h00, $past(cfg_q)})
    else $error("config read mismatch");

  // Each steering output is the registered copy of its configuration bit.
  a_sync_follows: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R3]
    ##1 ALTERNATE_SYNC_ENABLE_ENABLE_O == $past(cfg_q[`SICC_BIT_ALTERNATE_SYNC_ENABLE]))
    else $error("alternate_sync_enable mismatch");
  a_boost_follows: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R4]
    ##1 OUTPUT_DRIVE_BOOST_O == $past(cfg_q[`SICC_BIT_DRIVE_BOOST]))
    else $error("drive boost mismatch");
  a_out_reset: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R5]
    ##1 OUT_RESET_ENABLE_O == $past(cfg_q[`SICC_BIT_OUT_RESET]))
    else $error("out reset mismatch");
  a_cread_follows: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R6]
    ##1 CONTINUOUS_READ_ENABLE_O == $past(cfg_q[`SICC_BIT_CONT_READ]))
    else $error("continuous read enable mismatch");
  a_append_follows: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R8]
    ##1 DATA_STATUS_APPEND_O == $past(cfg_q[`SICC_BIT_DATA_STATUS]))
    else $error("status append mismatch");

  // Continuous read is gated by the conversion mode in both directions.
  a_cread_gate: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R7]
    CONT_READ_ACTIVE_O |-> $past(ADC_MODE_I) == `SICC_MODE_CONTINUOUS)
    else $error("continuous read outside mode");
  a_cread_on: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R15]
    (cfg_q[`SICC_BIT_CONT_READ] && ADC_MODE_I == `SICC_MODE_CONTINUOUS) |=> CONT_READ_ACTIVE_O)
    else $error("continuous read not active");

  // Integrity checker: capture, detect, hold and clear.
  a_ref_capture: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R16]
    (chk_q == SICC_CHK_ARM) |=> ref_q == $past(live_sum))
    else $error("reference not captured");
  a_error_set: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R9]
    (chk_q == SICC_CHK_WATCH && chk_en && live_sum != ref_q) |=> ##1 INTEGRITY_ERROR_O)
    else $error("change not flagged");
  a_error_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R13]
    (err_q && chk_en) |=> err_q)
    else $error("error dropped while enabled");
  a_error_clear: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R10]
    !chk_en |=> !err_q)
    else $error("error not cleared");

  // Checksum port reads zero while off and the live fold while on.
  a_chk_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R14]
    (RD_STB_I && addr_hit(ADDR_I, `SICC_CHK_ADDR) && !chk_en) |=> RDATA_O == 24'h000000)
    else $error("checksum not zero");
  a_chk_value: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R14]
    (RD_STB_I && addr_hit(ADDR_I, `SICC_CHK_ADDR) && chk_en) |=> RDATA_O == $past(live_sum))
    else $error("checksum read mismatch");
endmodule

// ### verif/sicc_host.sv
// Host model that issues register writes and reads to the configuration block.
`timescale 1ns/1ps
module sicc_host (
  input  wire logic        clk_i,
  input  wire logic [23:0] rdata_i,
  output logic             wr_stb_o,
  output logic             rd_stb_o,
  output logic [5:0]       addr_o,
  output logic [15:0]      wdata_o
);
  // Bus starts idle with both strobes low.
  initial {wr_stb_o, rd_stb_o, addr_o, wdata_o} = '0;
  // One-cycle write; released lines show the inverse so stale values are never mistaken for data.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_stb_o <= 1'b1;
    addr_o   <= a;
    wdata_o  <= d;
    @(posedge clk_i);
    wr_stb_o <= 1'b0;
    addr_o   <= ~a;
    wdata_o  <= ~d;
  endtask
  // One-cycle read; data is taken one cycle after the strobe edge.
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clk_i);
    rd_stb_o <= 1'b1;
    addr_o   <= a;
    @(posedge clk_i);
    rd_stb_o <= 1'b0;
    addr_o   <= ~a;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
endmodule

// ### verif/test_serial_interface_config_checker.sv
// Self-checking bench for the configuration register and integrity checker.
`timescale 1ns/1ps
module test_serial_interface_config_checker;
  logic clk = 0, rst = 1, err_o;
  logic [2:0] mode = 3'h0;
  logic [191:0] user = {8{24'h5a3c01}} ^ 192'h123456789;
  logic [23:0] rdata, got;
  wire [4:0] outs;
  logic wr, rd, cra;
  logic [5:0] addr;
  logic [15:0] wdata;
  int error_cnt = 0, cmp_count = 0;
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  sicc_host host (.clk_i(clk), .rdata_i(rdata), .wr_stb_o(wr), .rd_stb_o(rd), .addr_o(addr), .wdata_o(wdata));
  sicc_top DUT (.REF_CLK_I(clk), .RST_I(rst), .WR_STB_I(wr), .RD_STB_I(rd), .ADDR_I(addr), .WDATA_I(wdata),
    .USER_REGS_I(user), .ADC_MODE_I(mode), .RDATA_O(rdata), .ALTERNATE_SYNC_ENABLE_ENABLE_O(outs[4]),
    .OUTPUT_DRIVE_BOOST_O(outs[3]), .OUT_RESET_ENABLE_O(outs[2]), .CONTINUOUS_READ_ENABLE_O(outs[1]),
    .CONT_READ_ACTIVE_O(cra), .DATA_STATUS_APPEND_O(outs[0]), .INTEGRITY_ERROR_O(err_o));
  ////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Lets the configuration outputs settle after a write.
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Each of bits 12, 11, 8, 7 and 6 alone reaches its output and reads back.
  task automatic t_bits();
    int b[5] = '{12, 11, 8, 7, 6};
    for (int i = 0; i < 5; i++)
    begin
      host.wr(6'h02, 16'h1 << b[i]);
      settle();
      chk("outs", 24'(5'h10 >> i), 24'(outs));
      host.rd(6'h02, got);
      chk("cfg", 24'(16'h1 << b[i]), got);
    end
    host.wr(6'h02, 16'hffff);
    host.rd(6'h02, got);
    chk("resv", 24'h0019e0, got);
    host.wr(6'h04, 16'h0000);
    host.rd(6'h02, got);
    chk("unmapped wr", 24'h0019e0, got);
    host.rd(6'h3f, got);
    chk("unmapped rd", 24'h0, got);
    host.wr(6'h02, 16'h0000);
  endtask
  // Continuous read is active only in continuous conversion mode.
  task automatic t_cont();
    mode <= 3'h1;
    host.wr(6'h02, 16'h0080);
    settle();
    chk("cra off", 24'h0, 24'(cra));
    @(posedge clk);
    mode <= 3'h0;
    settle();
    chk("cra on", 24'h1, 24'(cra));
    host.wr(6'h02, 16'h0000);
  endtask
  // Checksum, change detection and clear of the integrity flag.
  task automatic t_check();
    logic [23:0] x = '0;
    for (int k = 0; k < 8; k++) x ^= user[k*24+:24];
    host.rd(6'h03, got);
    chk("sum off", 24'h0, got);
    host.wr(6'h02, 16'h0020);
    settle();
    host.rd(6'h03, got);
    chk("sum", x, got);
    host.wr(6'h02, 16'h0060);
    settle();
    chk("no err", 24'h0, 24'(err_o));
    @(posedge clk);
    user[3*24+:24] <= ~user[3*24+:24];
    settle();
    chk("err", 24'h1, 24'(err_o));
    host.wr(6'h02, 16'h0000);
    settle();
    chk("err clr", 24'h0, 24'(err_o));
  endtask
  // A reset in mid-run drops a raised integrity error and every enable.
  task automatic t_reset();
    host.wr(6'h02, 16'h19e0);
    settle();
    chk("all on", 24'h1f, 24'(outs));
    @(posedge clk);
    user[0+:24] <= ~user[0+:24];
    settle();
    chk("err set", 24'h1, 24'(err_o));
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.rd(6'h02, got);
    chk("reset again", 24'h0, got | 24'(outs) | 24'(cra) | 24'(err_o));
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    results();
  end
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    host.rd(6'h02, got);
    chk("reset", 24'h0, got | 24'(outs) | 24'(err_o));
    t_bits();
    t_cont();
    t_check();
    t_reset();
    results();
  end
endmodule
